// *** src/dual_port_ram_pkg.sv ***
// constants, configuration types and helper functions for the dual port ram
// assumes a single system clock that samples all port pins
package dual_port_ram_pkg;

  localparam int MEM_BITS = 9216;
  localparam int DATA_W = 18;
  localparam int ADDR_W = 13;
  localparam int CS_W = 3;
  localparam int NUM_PORTS = 2;
  localparam int LANE_DATA_BITS = 8;
  localparam int LANE_BITS = 9;
  localparam int PHYS_W = 14;
  localparam int DEFAULT_WIDTH = 18;
  localparam logic [CS_W-1:0] DEFAULT_SELECT_MATCH = 3'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 18'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_ZERO = 13'h0000;

  typedef enum logic {
    unregistered_output = 1'b0,
    registered_output = 1'b1
  } pipelining_t;

  typedef enum logic [1:0] {
    normal_write = 2'b00,
    new_data_on_write = 2'b01,
    old_data_on_write = 2'b10
  } write_behaviour_t;

  typedef enum logic {
    async_reset = 1'b0,
    sync_reset = 1'b1
  } reset_style_t;

  typedef struct packed {
    logic clock;
    logic clock_enable;
    logic write_enable;
    logic reset;
    logic [CS_W-1:0] chip_select;
    logic [ADDR_W-1:0] address;
    logic [DATA_W-1:0] write_data;
  } port_in_t;

  localparam port_in_t PORT_IN_ZERO = '0;

  // used address bits for a port width
  function automatic int addr_width(input int width);
    case (width)
      1: addr_width = 13;
      2: addr_width = 12;
      4: addr_width = 11;
      9: addr_width = 10;
      default: addr_width = 9;
    endcase
  endfunction

  // low bits that carry data for a port width
  function automatic logic [DATA_W-1:0] width_mask(input int width);
    width_mask = DATA_W'((32'h1 << width) - 1);
  endfunction

  // physical bit of data bit i of word addr; narrow widths skip lane bit 8
  function automatic logic [PHYS_W-1:0] phys_bit(input int width, input logic [ADDR_W-1:0] addr, input int i);
    int d;
    int used;
    used = addr_width(width);
    d = int'(addr & ADDR_W'((32'h1 << used) - 1)) * width + i;
    if (width == LANE_BITS || width == DATA_W)
      phys_bit = PHYS_W'(d);
    else
      phys_bit = PHYS_W'((d / LANE_DATA_BITS) * LANE_BITS + (d % LANE_DATA_BITS));
  endfunction

endpackage

// *** src/true_dual_port_block_ram.sv ***
// true dual port embedded ram block, two independent sampled ports
// assumes port clocks are much slower than clk and port inputs settle around each port clock edge
`timescale 1ns/1ps
`default_nettype none

module true_dual_port_block_ram #(
  parameter int PORT_A_WIDTH = dual_port_ram_pkg::DEFAULT_WIDTH,
  parameter int PORT_B_WIDTH = dual_port_ram_pkg::DEFAULT_WIDTH,
  parameter dual_port_ram_pkg::pipelining_t PORT_A_OUTPUT_PIPELINING = dual_port_ram_pkg::unregistered_output,
  parameter dual_port_ram_pkg::pipelining_t PORT_B_OUTPUT_PIPELINING = dual_port_ram_pkg::unregistered_output,
  parameter dual_port_ram_pkg::write_behaviour_t PORT_A_WRITE_BEHAVIOUR = dual_port_ram_pkg::normal_write,
  parameter dual_port_ram_pkg::write_behaviour_t PORT_B_WRITE_BEHAVIOUR = dual_port_ram_pkg::normal_write,
  parameter logic [2:0] PORT_A_SELECT_MATCH = dual_port_ram_pkg::DEFAULT_SELECT_MATCH,
  parameter logic [2:0] PORT_B_SELECT_MATCH = dual_port_ram_pkg::DEFAULT_SELECT_MATCH,
  parameter dual_port_ram_pkg::reset_style_t RESET_STYLE = dual_port_ram_pkg::async_reset,
  parameter bit GLOBAL_SET_RESET_OPTION = 1'b1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic global_set_reset,
  input wire logic port_a_clock,
  input wire logic port_a_clock_enable,
  input wire logic port_a_write_enable,
  input wire logic port_a_reset,
  input wire logic [dual_port_ram_pkg::CS_W-1:0] port_a_chip_select,
  input wire logic [dual_port_ram_pkg::ADDR_W-1:0] port_a_address,
  input wire logic [dual_port_ram_pkg::DATA_W-1:0] port_a_write_data,
  output logic [dual_port_ram_pkg::DATA_W-1:0] port_a_read_data,
  input wire logic port_b_clock,
  input wire logic port_b_clock_enable,
  input wire logic port_b_write_enable,
  input wire logic port_b_reset,
  input wire logic [dual_port_ram_pkg::CS_W-1:0] port_b_chip_select,
  input wire logic [dual_port_ram_pkg::ADDR_W-1:0] port_b_address,
  input wire logic [dual_port_ram_pkg::DATA_W-1:0] port_b_write_data,
  output logic [dual_port_ram_pkg::DATA_W-1:0] port_b_read_data
);
  import dual_port_ram_pkg::*;

  // ----------------------------------------------------------------
  // per port configuration
  // ----------------------------------------------------------------
  localparam int PORT_WIDTH [NUM_PORTS] = '{PORT_A_WIDTH, PORT_B_WIDTH};
  localparam pipelining_t PORT_PIPE [NUM_PORTS] = '{PORT_A_OUTPUT_PIPELINING, PORT_B_OUTPUT_PIPELINING};
  localparam write_behaviour_t PORT_MODE [NUM_PORTS] = '{PORT_A_WRITE_BEHAVIOUR, PORT_B_WRITE_BEHAVIOUR};
  localparam logic [CS_W-1:0] PORT_MATCH [NUM_PORTS] = '{PORT_A_SELECT_MATCH, PORT_B_SELECT_MATCH};

  port_in_t pin [NUM_PORTS];
  logic acc_we [NUM_PORTS];
  logic [ADDR_W-1:0] acc_addr [NUM_PORTS];
  logic [DATA_W-1:0] acc_data [NUM_PORTS];
  logic [DATA_W-1:0] out_reg [NUM_PORTS];

  // shared storage, never reset
  logic mem [MEM_BITS];

  assign pin[0] = '{clock: port_a_clock, clock_enable: port_a_clock_enable, write_enable: port_a_write_enable,
                    reset: port_a_reset, chip_select: port_a_chip_select, address: port_a_address,
                    write_data: port_a_write_data};
  assign pin[1] = '{clock: port_b_clock, clock_enable: port_b_clock_enable, write_enable: port_b_write_enable,
                    reset: port_b_reset, chip_select: port_b_chip_select, address: port_b_address,
                    write_data: port_b_write_data};
  assign port_a_read_data = out_reg[0];
  assign port_b_read_data = out_reg[1];

  // ----------------------------------------------------------------
  // global set/reset sampling
  // ----------------------------------------------------------------
  logic gsr1_reg;
  logic gsr2_reg;
  logic gsr3_reg;
  logic gsr_level_reg;
  logic gsr_clear;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      gsr1_reg <= 1'b0;
      gsr2_reg <= 1'b0;
      gsr3_reg <= 1'b0;
      gsr_level_reg <= 1'b0;
    end else begin
      gsr1_reg <= global_set_reset;
      gsr2_reg <= gsr1_reg;
      gsr3_reg <= gsr2_reg;
      if (gsr2_reg == gsr3_reg)
        gsr_level_reg <= gsr3_reg;
    end
  end

  assign gsr_clear = gsr_level_reg & GLOBAL_SET_RESET_OPTION;

  // ----------------------------------------------------------------
  // port logic
  // ----------------------------------------------------------------
  for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
    port_in_t s1_reg;
    port_in_t s2_reg;
    port_in_t s3_reg;
    logic clk_level_reg;
    logic acc_reg;
    logic we_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_reg;
    logic [DATA_W-1:0] core_reg;
    logic [DATA_W-1:0] rd_word;
    logic [DATA_W-1:0] core_next;
    logic port_edge;
    logic selected;
    logic take;
    logic clear_now;
    logic unreg_load;
    logic reg_load;

    // three-stage sampling of all port pins, clock included
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        s1_reg <= PORT_IN_ZERO;
        s2_reg <= PORT_IN_ZERO;
        s3_reg <= PORT_IN_ZERO;
        clk_level_reg <= 1'b0;
      end else begin
        s1_reg <= pin[p];
        s2_reg <= s1_reg;
        s3_reg <= s2_reg;
        if (s2_reg.clock == s3_reg.clock)
          clk_level_reg <= s3_reg.clock;
      end
    end

    assign port_edge = s2_reg.clock & s3_reg.clock & ~clk_level_reg;
    assign selected = (s3_reg.chip_select == PORT_MATCH[p]);
    assign clear_now = gsr_clear | (s3_reg.reset & ((RESET_STYLE == async_reset) | port_edge));
    assign take = port_edge & s3_reg.clock_enable & ~s3_reg.reset;

    // input registers at the array; access follows one clk later
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        acc_reg <= 1'b0;
        we_reg <= 1'b0;
        addr_reg <= ADDR_ZERO;
        data_reg <= DATA_ZERO;
      end else if (clear_now) begin
        acc_reg <= 1'b0;
        we_reg <= 1'b0;
        addr_reg <= ADDR_ZERO;
        data_reg <= DATA_ZERO;
      end else begin
        acc_reg <= take & selected;
        if (take) begin
          addr_reg <= s3_reg.address;
          data_reg <= s3_reg.write_data & width_mask(PORT_WIDTH[p]);
          we_reg <= s3_reg.write_enable & selected;
        end
      end
    end

    // word read before this cycle's write lands
    always_comb begin
      rd_word = DATA_ZERO;
      for (int i = 0; i < DATA_W; i++) begin
        if (i < PORT_WIDTH[p])
          rd_word[i] = mem[phys_bit(PORT_WIDTH[p], addr_reg, i)];
      end
    end

    always_comb begin
      core_next = core_reg;
      if (!we_reg)
        core_next = rd_word;
      else begin
        case (PORT_MODE[p])
          new_data_on_write: core_next = data_reg;
          old_data_on_write: core_next = rd_word;
          default: core_next = core_reg;
        endcase
      end
    end

    assign unreg_load = acc_reg & (PORT_PIPE[p] == unregistered_output);
    assign reg_load = take & (PORT_PIPE[p] == registered_output);

    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        core_reg <= DATA_ZERO;
        out_reg[p] <= DATA_ZERO;
      end else if (clear_now) begin
        core_reg <= DATA_ZERO;
        out_reg[p] <= DATA_ZERO;
      end else begin
        if (acc_reg)
          core_reg <= core_next;
        if (unreg_load)
          out_reg[p] <= core_next;
        else if (reg_load)
          out_reg[p] <= core_reg;
      end
    end

    assign acc_we[p] = acc_reg & we_reg;
    assign acc_addr[p] = addr_reg;
    assign acc_data[p] = data_reg;
  end

  // ----------------------------------------------------------------
  // array writes, port b last on collision
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    for (int p = 0; p < NUM_PORTS; p++) begin
      if (acc_we[p]) begin
        for (int i = 0; i < DATA_W; i++) begin
          if (i < PORT_WIDTH[p])
            mem[phys_bit(PORT_WIDTH[p], acc_addr[p], i)] <= acc_data[p][i];
        end
      end
    end
  end

endmodule // true_dual_port_block_ram

`default_nettype wire

// *** tb/dual_port_ram_monitor.sv ***
// pin checker for the true dual port ram block
// assumes it is bound to the block's top module and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module dual_port_ram_monitor import dual_port_ram_pkg::*; #(
  parameter logic [2:0] A_MATCH = 3'h0,
  parameter write_behaviour_t A_MODE = normal_write,
  parameter int A_WIDTH = 18
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic global_set_reset,
  input wire logic port_a_clock,
  input wire logic port_a_clock_enable,
  input wire logic port_a_write_enable,
  input wire logic port_a_reset,
  input wire logic [2:0] port_a_chip_select,
  input wire logic [17:0] port_a_write_data,
  input wire logic [17:0] port_a_read_data,
  input wire logic port_b_clock,
  input wire logic port_b_reset,
  input wire logic [17:0] port_b_read_data
);
  logic [3:0] a_since, b_since;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      a_since <= 4'hf;
      b_since <= 4'hf;
    end else begin
      a_since <= $rose(port_a_clock) ? 4'h0 : (a_since == 4'hf ? a_since : a_since + 4'h1);
      b_since <= $rose(port_b_clock) ? 4'h0 : (b_since == 4'hf ? b_since : b_since + 4'h1);
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_release_zero: assert property ($rose(resetn) |-> port_a_read_data == DATA_ZERO && port_b_read_data == DATA_ZERO)
    else $error("read data not zero after reset");
  a_gsr_clear: assert property (global_set_reset[*6] |-> port_a_read_data == DATA_ZERO && port_b_read_data == DATA_ZERO)
    else $error("global reset did not clear outputs");
  a_port_reset: assert property (port_a_reset[*6] |-> port_a_read_data == DATA_ZERO)
    else $error("port a reset did not clear output");
  a_reset_isolated: assert property ((port_a_reset && !port_b_reset && !port_b_clock && !global_set_reset)[*6]
    |-> $stable(port_b_read_data))
    else $error("port a reset disturbed port b");
  a_answer_a: assert property ($changed(port_a_read_data) && port_a_read_data != DATA_ZERO |-> a_since < 4'h8)
    else $error("port a output changed without a port edge");
  a_answer_b: assert property ($changed(port_b_read_data) && port_b_read_data != DATA_ZERO |-> b_since < 4'h8)
    else $error("port b output changed without a port edge");
  a_ce_hold: assert property ($rose(port_a_clock) && !port_a_clock_enable |-> ##1 $stable(port_a_read_data)[*7])
    else $error("disabled port a edge moved output");
  a_cs_hold: assert property ($rose(port_a_clock) && port_a_chip_select != A_MATCH
    |-> ##1 $stable(port_a_read_data)[*7])
    else $error("unselected port a edge moved output");
  a_new_data: assert property (A_MODE == new_data_on_write && A_WIDTH == DATA_W && $rose(port_a_clock)
    && port_a_clock_enable && port_a_write_enable && port_a_chip_select == A_MATCH && !port_a_reset
    |-> ##[4:7] port_a_read_data == port_a_write_data)
    else $error("port a write did not show new data");
endmodule // dual_port_ram_monitor
bind true_dual_port_block_ram dual_port_ram_monitor #(.A_MATCH(PORT_A_SELECT_MATCH), .A_MODE(PORT_A_WRITE_BEHAVIOUR),
  .A_WIDTH(PORT_A_WIDTH)) monitor_inst (.clk, .resetn, .global_set_reset, .port_a_clock, .port_a_clock_enable,
  .port_a_write_enable, .port_a_reset, .port_a_chip_select, .port_a_write_data, .port_a_read_data, .port_b_clock,
  .port_b_reset, .port_b_read_data);
`default_nettype wire

// *** tb/port_user_model.sv ***
// user logic driving one port of the ram
// assumes the ram samples port pins with clk
`timescale 1ns/1ps
`default_nettype none
module port_user_model (
  input wire logic clk,
  output var dual_port_ram_pkg::port_in_t p
);
  import dual_port_ram_pkg::*;
  initial p = PORT_IN_ZERO;
  // one port cycle: clock high 4 clk, low 4 clk, then address and data driven inverted
  task automatic access(input logic ce, input logic we, input logic [2:0] cs, input logic [12:0] a,
    input logic [17:0] d);
    @(posedge clk);
    p.clock_enable <= ce;
    p.write_enable <= we;
    p.chip_select <= cs;
    p.address <= a;
    p.write_data <= d;
    p.clock <= 1'b1;
    repeat (4) @(posedge clk);
    p.clock <= 1'b0;
    repeat (4) @(posedge clk);
    p.address <= ~a;
    p.write_data <= ~d;
  endtask
  task automatic set_reset(input logic r);
    @(posedge clk);
    p.reset <= r;
  endtask
endmodule // port_user_model
`default_nettype wire

// *** tb/true_dual_port_block_ram_tb_top.sv ***
// self-checking bench for the true dual port ram block
// assumes port_user_model and the bound monitor are compiled first
`timescale 1ns/1ps
`default_nettype none
module true_dual_port_block_ram_tb_top;
  import dual_port_ram_pkg::*;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic global_set_reset = 1'b0;
  port_in_t pa, pb, pc, pd;
  logic [17:0] a_rd, b_rd, c_rd, d_rd;
  int n_errors = 0;
  int num_checks = 0;
  always #50 clk = ~clk;
  port_user_model model_a (.clk(clk), .p(pa));
  port_user_model model_b (.clk(clk), .p(pb));
  port_user_model model_c (.clk(clk), .p(pc));
  port_user_model model_d (.clk(clk), .p(pd));
  // second block: narrow widths, normal mode on port a, new data on write on port b, registered port a
  if (1'b1) begin : g_narrow
    true_dual_port_block_ram #(.PORT_A_WIDTH(4), .PORT_B_WIDTH(1), .PORT_A_OUTPUT_PIPELINING(registered_output),
      .PORT_B_WRITE_BEHAVIOUR(new_data_on_write)) true_dual_port_block_ram_inst (
      .clk(clk), .resetn(resetn), .global_set_reset(global_set_reset),
      .port_a_clock(pc.clock), .port_a_clock_enable(pc.clock_enable), .port_a_write_enable(pc.write_enable),
      .port_a_reset(pc.reset), .port_a_chip_select(pc.chip_select), .port_a_address(pc.address),
      .port_a_write_data(pc.write_data), .port_a_read_data(c_rd),
      .port_b_clock(pd.clock), .port_b_clock_enable(pd.clock_enable), .port_b_write_enable(pd.write_enable),
      .port_b_reset(pd.reset), .port_b_chip_select(pd.chip_select), .port_b_address(pd.address),
      .port_b_write_data(pd.write_data), .port_b_read_data(d_rd));
  end
  true_dual_port_block_ram #(.PORT_B_WIDTH(9), .PORT_B_OUTPUT_PIPELINING(registered_output),
    .PORT_A_WRITE_BEHAVIOUR(new_data_on_write), .PORT_B_WRITE_BEHAVIOUR(old_data_on_write),
    .PORT_A_SELECT_MATCH(3'h5), .PORT_B_SELECT_MATCH(3'h2)) true_dual_port_block_ram_inst (
    .clk(clk), .resetn(resetn), .global_set_reset(global_set_reset),
    .port_a_clock(pa.clock), .port_a_clock_enable(pa.clock_enable), .port_a_write_enable(pa.write_enable),
    .port_a_reset(pa.reset), .port_a_chip_select(pa.chip_select), .port_a_address(pa.address),
    .port_a_write_data(pa.write_data), .port_a_read_data(a_rd),
    .port_b_clock(pb.clock), .port_b_clock_enable(pb.clock_enable), .port_b_write_enable(pb.write_enable),
    .port_b_reset(pb.reset), .port_b_chip_select(pb.chip_select), .port_b_address(pb.address),
    .port_b_write_data(pb.write_data), .port_b_read_data(b_rd));
  task automatic check(input string what, input logic [17:0] seen, input logic [17:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    n_errors++;
    complete_run();
  end
  initial begin
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    check("a idle", a_rd, 18'h0_0000);
    model_a.access(1'b1, 1'b1, 3'h5, 13'h0001, 18'h2_abcd);
    check("a write", a_rd, 18'h2_abcd);
    model_a.access(1'b1, 1'b0, 3'h5, 13'h0001, 18'h0_0000);
    check("a read", a_rd, 18'h2_abcd);
    model_b.access(1'b1, 1'b0, 3'h2, 13'h0002, 18'h0_0000);
    check("b first", b_rd, 18'h0_0000);
    model_b.access(1'b1, 1'b0, 3'h2, 13'h0003, 18'h0_0000);
    check("b low lane", b_rd, 18'h0_01cd);
    model_b.access(1'b1, 1'b1, 3'h2, 13'h0003, 18'h0_00aa);
    check("b high lane", b_rd, 18'h0_0155);
    model_b.access(1'b1, 1'b0, 3'h2, 13'h0002, 18'h0_0000);
    check("b old data", b_rd, 18'h0_0155);
    model_a.access(1'b1, 1'b0, 3'h5, 13'h0001, 18'h0_0000);
    check("a shared", a_rd, 18'h1_55cd);
    model_a.access(1'b1, 1'b1, 3'h3, 13'h0001, 18'h0_0000);
    model_a.access(1'b0, 1'b1, 3'h5, 13'h0001, 18'h0_0000);
    model_a.access(1'b1, 1'b0, 3'h5, 13'h0001, 18'h0_0000);
    check("a no write", a_rd, 18'h1_55cd);
    model_a.set_reset(1'b1);
    repeat (8) @(posedge clk);
    check("a reset", a_rd, 18'h0_0000);
    check("b kept", b_rd, 18'h0_0155);
    model_a.set_reset(1'b0);
    repeat (6) @(posedge clk);
    model_a.access(1'b1, 1'b0, 3'h5, 13'h0001, 18'h0_0000);
    check("a array kept", a_rd, 18'h1_55cd);
    global_set_reset <= 1'b1;
    repeat (8) @(posedge clk);
    check("gsr a", a_rd, 18'h0_0000);
    check("gsr b", b_rd, 18'h0_0000);
    global_set_reset <= 1'b0;
    repeat (6) @(posedge clk);
    model_b.access(1'b1, 1'b0, 3'h2, 13'h0003, 18'h0_0000);
    model_b.access(1'b1, 1'b0, 3'h2, 13'h0002, 18'h0_0000);
    check("b after gsr", b_rd, 18'h0_00aa);
    model_c.access(1'b1, 1'b1, 3'h0, 13'h0002, 18'h0_000b);
    model_c.access(1'b1, 1'b0, 3'h0, 13'h0002, 18'h0_0000);
    check("c first", c_rd, 18'h0_0000);
    model_c.access(1'b1, 1'b1, 3'h0, 13'h0002, 18'h3_fff5);
    check("c pipe", c_rd, 18'h0_000b);
    model_c.access(1'b1, 1'b0, 3'h0, 13'h0003, 18'h0_0000);
    check("c normal hold", c_rd, 18'h0_000b);
    model_d.access(1'b1, 1'b1, 3'h0, 13'h0009, 18'h0_0001);
    check("d new data", d_rd, 18'h0_0001);
    model_d.access(1'b1, 1'b0, 3'h0, 13'h000b, 18'h0_0000);
    check("d bit 11", d_rd, 18'h0_0000);
    model_d.access(1'b1, 1'b0, 3'h0, 13'h0008, 18'h0_0000);
    check("d bit 8", d_rd, 18'h0_0001);
    model_c.access(1'b1, 1'b0, 3'h0, 13'h0002, 18'h0_0000);
    model_c.access(1'b1, 1'b0, 3'h0, 13'h0005, 18'h0_0000);
    check("c shared", c_rd, 18'h0_0007);
    complete_run();
  end
endmodule // true_dual_port_block_ram_tb_top
`default_nettype wire
